// [core/mms_staging.v]
// multi-motor staging controller with on/off comparator, wishbone slave
`timescale 1ns/100ps
`include "mms_consts.vh"

// Behaviour
// RL1 - output on above on level, hold between
// RL2 - off level clamped to zero..on level
// RL3 - source selector, default voltage input, function 34
// RL4 - mode code 3 enables motor staging
// RL5 - aux motor count 0..4, default 4
// RL6 - start motors circularly from first aux
// RL7 - stop motors in reverse start order
// RL8 - readable count of running aux motors
// RL9 - start needs frequency above start frequency
// RL10 - start needs start delay elapsed
// RL11 - start needs pid error above threshold
// RL12 - stop needs frequency below stop frequency
// RL13 - stop needs stop delay elapsed
// RL14 - stop needs pid error below threshold
// RL15 - on start, suspend pid, decel ramp
// RL16 - on stop, suspend pid, accel ramp
// RL17 - relays 1, 2 and first open collector; the code also drives a fourth motor on aux_relay_o[3], ext
// RL18 - timers restart on lost condition, one step
module mms_staging #(
  parameter TICK_CYCLES = `MMS_TICK_MS * `MMS_NS_PER_MS / `MMS_CLK_PERIOD_NS
) (
  input  wire        clk_i,                  // system clock
  input  wire        rst_i,                  // sync reset, active high
  input  wire        wb_cyc_i,               // wishbone cycle
  input  wire        wb_stb_i,               // wishbone strobe
  input  wire        wb_we_i,                // wishbone write
  input  wire [7:0]  wb_adr_i,               // byte address
  input  wire [3:0]  wb_sel_i,               // byte enables
  input  wire [31:0] wb_dat_i,               // write data
  output reg  [31:0] wb_dat_o,               // read data
  output reg         wb_ack_o,               // acknowledge
  input  wire [15:0] analog_in0_i,           // analog input 0, 0.01 %
  input  wire [15:0] voltage_analog_input_i, // analog input 1, 0.01 %
  input  wire [15:0] analog_in2_i,           // analog input 2, 0.01 %
  input  wire [15:0] analog_in3_i,           // analog input 3, 0.01 %
  input  wire [15:0] main_freq_i,            // main motor freq, 0.01 Hz
  input  wire [15:0] pid_error_i,            // signed ref minus fbk, 0.01 %
  output reg         onoff_out_o,            // comparator output
  output reg  [3:0]  aux_relay_o,            // relay1, relay2, first oc, ext
  output reg  [2:0]  running_aux_count_o,    // running aux motors
  output reg         pid_suspend_o,          // main motor in aux ramp
  output reg  [15:0] ramp_target_o,          // ramp target, 0.01 Hz
  output reg  [15:0] ramp_time_o             // ramp time, 0.1 s
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clamp a 16-bit value into lo..hi
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // circular motor index: (first-1+off) mod n
  function [1:0] motor_idx;
    input [2:0] first;
    input [2:0] off;
    input [2:0] n;
    reg   [3:0] s;
    integer     k;
    begin
      s = {1'b0, first} - 4'h1 + {1'b0, off};
      for (k = 0; k < 3; k = k + 1) begin
        if (n != 3'h0 && s >= {1'b0, n}) begin
          s = s - {1'b0, n};
        end
      end
      motor_idx = s[1:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [3:0]  mode_q;                 // application mode
  reg  [1:0]  on_off_source_select_q; // analog source for comparator
  reg  [2:0]  first_aux_select_q;     // first motor to start
  reg  [2:0]  aux_motor_count_q;      // motors taking part
  reg  [15:0] on_level_q;             // comparator on level
  reg  [15:0] off_level_q;            // comparator off level
  reg  [15:0] pdiff_q;                // pressure difference threshold
  reg  [15:0] start_dly_q;            // aux start delay
  reg  [15:0] stop_dly_q;             // aux stop delay
  reg  [15:0] accel_q;                // aux accel time
  reg  [15:0] decel_q;                // aux decel time
  reg  [15:0] start_f_q [0:`MMS_NAUX-1]; // start frequencies
  reg  [15:0] stop_f_q  [0:`MMS_NAUX-1]; // stop frequencies
  reg  [31:0] tick_cnt_q;             // tick divider
  reg         tick_q;                 // 100 ms enable pulse
  reg  [15:0] start_tmr_q;            // start delay timer
  reg  [15:0] stop_tmr_q;             // stop delay timer
  reg  [15:0] ramp_cnt_q;             // ramp elapsed time
  reg  [2:0]  cnt_q;                  // running motor count
  integer     i;

  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr    = wb_req & wb_we_i & (&wb_sel_i[1:0]);
  wire [1:0]  tidx     = wb_adr_i[`MMS_ADR_IDX_MSB:`MMS_ADR_IDX_LSB];
  wire [15:0] wv       = wb_dat_i[15:0];
  wire [31:0] ctrl_w   = {17'h0, aux_motor_count_q, 1'b0, first_aux_select_q,
                          2'h0, on_off_source_select_q, mode_q};
  wire        mmc_en   = (mode_q == `MMS_MODE_MMC);                   // see RL4
  wire [1:0]  next_idx = motor_idx(first_aux_select_q, cnt_q, aux_motor_count_q);        // see RL6
  wire [1:0]  last_idx = motor_idx(first_aux_select_q, cnt_q - 3'h1, aux_motor_count_q); // see RL7
  wire signed [15:0] perr = pid_error_i;
  wire signed [15:0] pthr = pdiff_q;

  // ---------------------------------------------------------------
  // wishbone slave: one-cycle ack, unmapped reads zero
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= 32'h0;
      mode_q                 <= 4'h0;
      on_off_source_select_q <= `MMS_SRC_VOLT;   // see RL3
      first_aux_select_q     <= `MMS_RST_FIRST;
      aux_motor_count_q      <= `MMS_RST_NUM;    // see RL5
      on_level_q             <= `MMS_RST_ON;     // see RL1
      off_level_q            <= `MMS_RST_OFF;    // see RL2
      pdiff_q                <= `MMS_RST_PDIFF;
      start_dly_q            <= `MMS_RST_DLY;
      stop_dly_q             <= `MMS_RST_DLY;
      accel_q                <= `MMS_RST_RAMP;
      decel_q                <= `MMS_RST_RAMP;
      for (i = 0; i < `MMS_NAUX; i = i + 1) begin
        start_f_q[i] <= `MMS_RST_START_F;
        stop_f_q[i]  <= `MMS_RST_STOP_F;
      end
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      // register writes, values clamped to legal ranges
      if (wb_wr) begin
        if (wb_adr_i == `MMS_ADR_CTRL) begin
          mode_q                 <= wb_dat_i[`MMS_F_MODE_MSB:`MMS_F_MODE_LSB];
          on_off_source_select_q <= wb_dat_i[`MMS_F_SRC_MSB:`MMS_F_SRC_LSB];
          aux_motor_count_q      <= (wb_dat_i[`MMS_F_NUM_MSB:`MMS_F_NUM_LSB] > `MMS_NUM_MAX) ?
                                    `MMS_NUM_MAX : wb_dat_i[`MMS_F_NUM_MSB:`MMS_F_NUM_LSB]; // see RL5
          if (wb_dat_i[`MMS_F_FIRST_MSB:`MMS_F_FIRST_LSB] == 3'h0) begin
            first_aux_select_q <= 3'h1;
          end else if (wb_dat_i[`MMS_F_FIRST_MSB:`MMS_F_FIRST_LSB] > `MMS_NUM_MAX) begin
            first_aux_select_q <= `MMS_NUM_MAX;
          end else begin
            first_aux_select_q <= wb_dat_i[`MMS_F_FIRST_MSB:`MMS_F_FIRST_LSB];
          end
        end else if (wb_adr_i == `MMS_ADR_ON_LEVEL) begin
          on_level_q <= clamp16(wv, `MMS_ON_MIN, `MMS_ON_MAX);            // see RL1
          if (off_level_q > clamp16(wv, `MMS_ON_MIN, `MMS_ON_MAX)) begin
            off_level_q <= clamp16(wv, `MMS_ON_MIN, `MMS_ON_MAX);         // see RL2
          end
        end else if (wb_adr_i == `MMS_ADR_OFF_LEVEL) begin
          off_level_q <= clamp16(wv, 16'h0, on_level_q);                   // see RL2
        end else if (wb_adr_i == `MMS_ADR_PDIFF) begin
          pdiff_q <= clamp16(wv, 16'h0, `MMS_PDIFF_MAX);
        end else if (wb_adr_i == `MMS_ADR_START_DLY) begin
          start_dly_q <= clamp16(wv, 16'h0, `MMS_DLY_MAX);
        end else if (wb_adr_i == `MMS_ADR_STOP_DLY) begin
          stop_dly_q <= clamp16(wv, 16'h0, `MMS_DLY_MAX);
        end else if (wb_adr_i == `MMS_ADR_ACCEL) begin
          accel_q <= clamp16(wv, 16'h0, `MMS_RAMP_MAX);
        end else if (wb_adr_i == `MMS_ADR_DECEL) begin
          decel_q <= clamp16(wv, 16'h0, `MMS_RAMP_MAX);
        end else if ((wb_adr_i & `MMS_ADR_TBL_MASK) == `MMS_ADR_START_F0) begin
          start_f_q[tidx] <= clamp16(wv, 16'h0, `MMS_FREQ_MAX);
        end else if ((wb_adr_i & `MMS_ADR_TBL_MASK) == `MMS_ADR_STOP_F0) begin
          stop_f_q[tidx] <= clamp16(wv, 16'h0, `MMS_FREQ_MAX);
        end
      end
      // register reads
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `MMS_ADR_CTRL) begin
          wb_dat_o <= ctrl_w;
        end else if (wb_adr_i == `MMS_ADR_ON_LEVEL) begin
          wb_dat_o <= {16'h0, on_level_q};
        end else if (wb_adr_i == `MMS_ADR_OFF_LEVEL) begin
          wb_dat_o <= {16'h0, off_level_q};
        end else if (wb_adr_i == `MMS_ADR_PDIFF) begin
          wb_dat_o <= {16'h0, pdiff_q};
        end else if (wb_adr_i == `MMS_ADR_START_DLY) begin
          wb_dat_o <= {16'h0, start_dly_q};
        end else if (wb_adr_i == `MMS_ADR_STOP_DLY) begin
          wb_dat_o <= {16'h0, stop_dly_q};
        end else if (wb_adr_i == `MMS_ADR_ACCEL) begin
          wb_dat_o <= {16'h0, accel_q};
        end else if (wb_adr_i == `MMS_ADR_DECEL) begin
          wb_dat_o <= {16'h0, decel_q};
        end else if ((wb_adr_i & `MMS_ADR_TBL_MASK) == `MMS_ADR_START_F0) begin
          wb_dat_o <= {16'h0, start_f_q[tidx]};
        end else if ((wb_adr_i & `MMS_ADR_TBL_MASK) == `MMS_ADR_STOP_F0) begin
          wb_dat_o <= {16'h0, stop_f_q[tidx]};
        end else if (wb_adr_i == `MMS_ADR_STATUS) begin
          // status: count, relays, comparator, ramp
          wb_dat_o <= {`MMS_FUNC_MMC, `MMS_FUNC_ONOFF, 6'h0, pid_suspend_o, onoff_out_o,
                       aux_relay_o, 1'b0, cnt_q};                        // see RL8
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control tick divider
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // on/off comparator with hysteresis
  // ---------------------------------------------------------------
  reg [15:0] src_val;
  always @* begin
    case (on_off_source_select_q)                                       // see RL3
      2'h0:    src_val = analog_in0_i;
      2'h1:    src_val = voltage_analog_input_i;
      2'h2:    src_val = analog_in2_i;
      default: src_val = analog_in3_i;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      onoff_out_o <= 1'b0;
    end else if (src_val > on_level_q) begin
      onoff_out_o <= 1'b1;                                              // see RL1
    end else if (src_val < off_level_q) begin
      onoff_out_o <= 1'b0;                                              // see RL2
    end
  end

  // ---------------------------------------------------------------
  // staging: delay timers, relays, count, main motor ramp
  // ---------------------------------------------------------------
  wire start_cond = mmc_en && !pid_suspend_o && (cnt_q < aux_motor_count_q) &&
                    (main_freq_i > start_f_q[next_idx]) &&              // see RL9
                    (perr > pthr);                                      // see RL11
  wire stop_cond  = mmc_en && !pid_suspend_o && (cnt_q != 3'h0) &&
                    (main_freq_i < stop_f_q[last_idx]) &&               // see RL12
                    (perr < pthr);                                      // see RL14

  always @(posedge clk_i) begin
    if (rst_i || !mmc_en) begin
      start_tmr_q         <= 16'h0;
      stop_tmr_q          <= 16'h0;
      ramp_cnt_q          <= 16'h0;
      cnt_q               <= 3'h0;
      aux_relay_o         <= 4'h0;
      running_aux_count_o <= 3'h0;
      pid_suspend_o       <= 1'b0;
      ramp_target_o       <= 16'h0;
      ramp_time_o         <= 16'h0;
    end else begin
      running_aux_count_o <= cnt_q;                                     // see RL8
      if (pid_suspend_o) begin
        // ramp runs for its set time, then pid resumes
        if (ramp_cnt_q >= ramp_time_o) begin
          pid_suspend_o <= 1'b0;
        end else if (tick_q) begin
          ramp_cnt_q <= ramp_cnt_q + 16'h1;
        end
      end
      // start side
      if (!start_cond) begin
        start_tmr_q <= 16'h0;                                           // see RL18
      end else if (start_tmr_q >= start_dly_q) begin
        aux_relay_o[next_idx] <= 1'b1;                                  // see RL17
        cnt_q                 <= cnt_q + 3'h1;                          // see RL6
        start_tmr_q           <= 16'h0;                                 // see RL18
        pid_suspend_o         <= 1'b1;                                  // see RL15
        ramp_cnt_q            <= 16'h0;
        ramp_target_o         <= stop_f_q[next_idx];                    // see RL15
        ramp_time_o           <= decel_q;
      end else if (tick_q) begin
        start_tmr_q <= start_tmr_q + 16'h1;                             // see RL10
      end
      // stop side
      if (!stop_cond) begin
        stop_tmr_q <= 16'h0;                                            // see RL18
      end else if (stop_tmr_q >= stop_dly_q) begin
        aux_relay_o[last_idx] <= 1'b0;                                  // see RL7
        cnt_q                 <= cnt_q - 3'h1;
        stop_tmr_q            <= 16'h0;
        pid_suspend_o         <= 1'b1;                                  // see RL16
        ramp_cnt_q            <= 16'h0;
        ramp_target_o         <= start_f_q[last_idx];                   // see RL16
        ramp_time_o           <= accel_q;
      end else if (tick_q) begin
        stop_tmr_q <= stop_tmr_q + 16'h1;                               // see RL13
      end
    end
  end

endmodule // mms_staging

// [core/mms_consts.vh]
// constants for the multi-motor staging controller
`ifndef MMS_CONSTS_VH
`define MMS_CONSTS_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MMS_CLK_PERIOD_NS   10
`define MMS_TICK_MS         100
`define MMS_NS_PER_MS       1000000

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MMS_ADR_CTRL        8'h00
`define MMS_ADR_ON_LEVEL    8'h04
`define MMS_ADR_OFF_LEVEL   8'h08
`define MMS_ADR_PDIFF       8'h0c
`define MMS_ADR_START_DLY   8'h10
`define MMS_ADR_STOP_DLY    8'h14
`define MMS_ADR_ACCEL       8'h18
`define MMS_ADR_DECEL       8'h1c
`define MMS_ADR_START_F0    8'h20
`define MMS_ADR_STOP_F0     8'h30
`define MMS_ADR_STATUS      8'h40
`define MMS_ADR_TBL_MASK    8'hf0
`define MMS_ADR_IDX_LSB     2
`define MMS_ADR_IDX_MSB     3

// ---------------------------------------------------------------
// ctrl field positions
// ---------------------------------------------------------------
`define MMS_F_MODE_LSB      0
`define MMS_F_MODE_MSB      3
`define MMS_F_SRC_LSB       4
`define MMS_F_SRC_MSB       5
`define MMS_F_FIRST_LSB     8
`define MMS_F_FIRST_MSB     10
`define MMS_F_NUM_LSB       12
`define MMS_F_NUM_MSB       14

// ---------------------------------------------------------------
// codes and reset values (levels 0.01 %, freq 0.01 Hz, time 0.1 s)
// ---------------------------------------------------------------
`define MMS_MODE_MMC        4'h3
`define MMS_SRC_VOLT        2'h1
`define MMS_FUNC_ONOFF      8'h22
`define MMS_FUNC_MMC        8'h18
`define MMS_RST_ON          16'h2328
`define MMS_RST_OFF         16'h03e8
`define MMS_ON_MIN          16'h03e8
`define MMS_ON_MAX          16'h2710
`define MMS_RST_PDIFF       16'h00c8
`define MMS_PDIFF_MAX       16'h2710
`define MMS_RST_DLY         16'h0258
`define MMS_DLY_MAX         16'h8ca0
`define MMS_RST_RAMP        16'h0014
`define MMS_RAMP_MAX        16'h1770
`define MMS_RST_START_F     16'h1387
`define MMS_RST_STOP_F      16'h05dc
`define MMS_FREQ_MAX        16'h1770
`define MMS_RST_FIRST       3'h1
`define MMS_RST_NUM         3'h4
`define MMS_NUM_MAX         3'h4
`define MMS_NAUX            4

`endif

// [testbench/mms_aux_plant.sv]
// contactor model of the auxiliary motors behind the relays
`timescale 1ns/100ps
module mms_aux_plant (
  input  wire       clk_i,      // system clock
  input  wire [3:0] relay_i,    // relay coil drives
  output reg  [3:0] motor_on_o  // contactors closed
);
  // contactor pulls in or drops out one cycle after its coil
  always @(posedge clk_i) begin
    motor_on_o <= relay_i;
  end
endmodule // mms_aux_plant

// [testbench/mms_staging_monitor.sv]
// port assertions for the staging controller
`timescale 1ns/100ps
module mms_staging_monitor (
  input wire        clk_i,                  // system clock
  input wire        rst_i,                  // sync reset
  input wire        wb_cyc_i,               // bus cycle
  input wire        wb_stb_i,               // bus strobe
  input wire        wb_ack_o,               // bus ack
  input wire [15:0] voltage_analog_input_i, // comparator source
  input wire [15:0] main_freq_i,            // main motor freq
  input wire [15:0] pid_error_i,            // pid error, signed
  input wire        onoff_out_o,            // comparator output
  input wire [3:0]  aux_relay_o,            // relay drives
  input wire [2:0]  running_aux_count_o,    // running count
  input wire        pid_suspend_o           // aux ramp active
);
  // ----------------------------------------
  // one clock domain, reset disables all
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack missing or longer than one cycle");
  onoff_rise_a: assert property ($rose(onoff_out_o) |-> $past(voltage_analog_input_i) > 16'h03e8)
    else $error("comparator switched on below the lowest on level");
  onoff_fall_a: assert property ($fell(onoff_out_o) |-> $past(voltage_analog_input_i) < 16'h2710)
    else $error("comparator switched off above the highest off level");
  count_match_a: assert property (!$past(rst_i) |-> running_aux_count_o == $countones($past(aux_relay_o)))
    else $error("running count differs from relays on");
  count_max_a: assert property (running_aux_count_o <= 3'h4)
    else $error("running count above four");
  one_step_a: assert property ($countones(aux_relay_o) <= $countones($past(aux_relay_o)) + 1)
    else $error("more than one motor added at once");
  start_cond_a: assert property ($countones(aux_relay_o) > $countones($past(aux_relay_o))
    |-> $signed($past(pid_error_i)) > 0 && $past(main_freq_i) > 16'h0000) else $error("motor added without cause");
  stop_cond_a: assert property (!$past(rst_i) && $countones(aux_relay_o) < $countones($past(aux_relay_o))
    |-> $past(main_freq_i) < 16'h1770) else $error("motor removed at high frequency");
  ramp_start_a: assert property ($countones(aux_relay_o) > $countones($past(aux_relay_o)) |-> ##[0:1] pid_suspend_o)
    else $error("no ramp after motor added");
  ramp_hold_a: assert property (pid_suspend_o && $past(pid_suspend_o) |-> $stable(aux_relay_o))
    else $error("staging moved during ramp");
endmodule // mms_staging_monitor

bind mms_staging mms_staging_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .voltage_analog_input_i(voltage_analog_input_i), .main_freq_i(main_freq_i),
  .pid_error_i(pid_error_i), .onoff_out_o(onoff_out_o), .aux_relay_o(aux_relay_o),
  .running_aux_count_o(running_aux_count_o), .pid_suspend_o(pid_suspend_o));

// [testbench/mms_staging_test.sv]
// self-checking bench for the staging controller
`timescale 1ns/100ps
`include "mms_consts.vh"
module mms_staging_test;
  reg         clk_i;       // clock
  reg         rst_i;       // reset
  reg         cyc_q;       // bus request
  reg         we_q;        // bus direction
  reg  [7:0]  adr_q;       // bus address
  reg  [31:0] wdat_q;      // write data
  reg  [15:0] volt_q;      // voltage input
  reg  [15:0] freq_q;      // main motor freq
  reg  [15:0] err_q;       // pid error
  wire [31:0] rdat;        // read data
  wire        ack;         // bus ack
  wire        onoff;       // comparator
  wire [3:0]  relay;       // relays
  wire [2:0]  cnt;         // running count
  wire        susp;        // ramp active
  wire [15:0] tgt;         // ramp target
  wire [15:0] rtime;       // ramp time
  wire [3:0]  motor;       // plant contactors
  integer     miscompares; // mismatches
  integer     tests_run;   // comparisons
  // address and reset value pairs, unmapped last
  localparam [479:0] TBL = {40'h00_00004110, 40'h04_00002328, 40'h08_000003e8, 40'h0c_000000c8,
    40'h10_00000258, 40'h14_00000258, 40'h18_00000014, 40'h1c_00000014,
    40'h20_00001387, 40'h3c_000005dc, 40'h40_18220000, 40'h80_00000000};

  // other sources carry the inverse so a wrong selection shows
  mms_staging #(.TICK_CYCLES(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_q), .wb_stb_i(cyc_q),
    .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(4'hf), .wb_dat_i(wdat_q), .wb_dat_o(rdat), .wb_ack_o(ack),
    .analog_in0_i(~volt_q), .voltage_analog_input_i(volt_q), .analog_in2_i(~volt_q), .analog_in3_i(~volt_q),
    .main_freq_i(freq_q), .pid_error_i(err_q), .onoff_out_o(onoff), .aux_relay_o(relay),
    .running_aux_count_o(cnt), .pid_suspend_o(susp), .ramp_target_o(tgt), .ramp_time_o(rtime));
  mms_aux_plant plant_u (.clk_i(clk_i), .relay_i(relay), .motor_on_o(motor));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // classic single cycle, held until ack is sampled
  task wb(input logic w, input [7:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      cyc_q <= 1'b1;
      we_q <= w;
      adr_q <= a;
      wdat_q <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = rdat;
      cyc_q <= 1'b0;
      if (n >= 50) begin
        chk("bus ack", 32'h1, 32'h0);
        give_verdict;
      end
      @(posedge clk_i);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    reg [31:0] q;
    begin
      wb(1'b0, a, 32'h0, q);
      chk(nm, e, q);
    end
  endtask
  // wait for a relay pattern, then check the ramp it launched
  task step(input [3:0] e, input [15:0] t, input [15:0] rt);
    integer n;
    begin
      n = 0;
      while (relay !== e && n < 3000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      chk("relays", {28'h0, e}, {28'h0, relay});
      if (n >= 3000)
        give_verdict;
      chk("suspend", 32'h1, {31'h0, susp});
      chk("ramp target", {16'h0, t}, {16'h0, tgt});
      chk("ramp time", {16'h0, rt}, {16'h0, rtime});
    end
  endtask
  task cmp_step(input [15:0] v, input e);
    begin
      volt_q <= v;
      repeat (3) @(posedge clk_i);
      chk("onoff", {31'h0, e}, {31'h0, onoff});
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    integer i;
    begin
      for (i = 11; i >= 0; i = i - 1)
        rd(TBL[i*40+32 +: 8], TBL[i*40 +: 32], "reset value");
      wr(`MMS_ADR_STATUS, 32'hffffffff);
      rd(`MMS_ADR_STATUS, 32'h18220000, "status ro");
    end
  endtask
  task t_cmp;
    begin
      wr(`MMS_ADR_OFF_LEVEL, 32'h00002710);
      rd(`MMS_ADR_OFF_LEVEL, 32'h00002328, "off clamp");
      wr(`MMS_ADR_ON_LEVEL, 32'h000001f4);
      rd(`MMS_ADR_ON_LEVEL, 32'h000003e8, "on clamp");
      wr(`MMS_ADR_ON_LEVEL, 32'h00002328);
      wr(`MMS_ADR_OFF_LEVEL, 32'h000003e8);
      cmp_step(16'h2329, 1'b1);
      cmp_step(16'h2328, 1'b1);
      cmp_step(16'h03e8, 1'b1);
      cmp_step(16'h03e7, 1'b0);
      cmp_step(16'h2327, 1'b0);
    end
  endtask
  task t_gate;
    begin
      wr(`MMS_ADR_START_DLY, 32'h4);
      wr(`MMS_ADR_STOP_DLY, 32'h2);
      wr(`MMS_ADR_ACCEL, 32'h2);
      wr(`MMS_ADR_DECEL, 32'h1);
      freq_q <= 16'h1388;
      err_q <= 16'h012c;
      repeat (100) @(posedge clk_i);
      chk("relays idle", 32'h0, {28'h0, relay});
      wr(`MMS_ADR_CTRL, 32'h00003213);
      repeat (23) @(posedge clk_i);
      freq_q <= 16'h1387;
      repeat (2) @(posedge clk_i);
      freq_q <= 16'h1388;
      repeat (30) @(posedge clk_i);
      chk("relays restart", 32'h0, {28'h0, relay});
    end
  endtask
  task t_up;
    begin
      step(4'b0010, 16'h05dc, 16'h0001);
      step(4'b0110, 16'h05dc, 16'h0001);
      step(4'b0111, 16'h05dc, 16'h0001);
      repeat (100) @(posedge clk_i);
      chk("relays full", 32'h7, {28'h0, relay});
      chk("count", 32'h3, {29'h0, cnt});
      chk("motors", 32'h7, {28'h0, motor});
    end
  endtask
  task t_down;
    begin
      freq_q <= 16'h03e8;
      err_q <= 16'h0064;
      step(4'b0110, 16'h1387, 16'h0002);
      step(4'b0010, 16'h1387, 16'h0002);
      step(4'b0000, 16'h1387, 16'h0002);
      // last ramp runs two ticks before the status shows idle
      repeat (30) @(posedge clk_i);
      chk("suspend end", 32'h0, {31'h0, susp});
      rd(`MMS_ADR_STATUS, 32'h18220000, "status idle");
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    cyc_q = 1'b0;
    we_q = 1'b0;
    adr_q = 8'h00;
    wdat_q = 32'h0;
    volt_q = 16'h0;
    freq_q = 16'h0;
    err_q = 16'h0;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_cmp;
    t_gate;
    t_up;
    t_down;
    give_verdict;
  end
endmodule // mms_staging_test
